// File: pkg/rcu_pkg.sv
package rcu_pkg;
  // clock and start-up timing
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned PWRT_MS = 72;
  localparam int unsigned PWRT_CYCLES = PWRT_MS * 1000 * CLK_MHZ;
  localparam int unsigned OST_TOSC = 1024;
  // one oscillator period is one clk_in period here
  localparam int unsigned OST_CYCLES = OST_TOSC * 1;
  localparam int unsigned CNT_W = 23;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PCL = 8'h02;
  localparam logic [7:0] IDX_STATUS = 8'h03;
  localparam logic [7:0] IDX_PC_HIGH_LATCH = 8'h0a;
  localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0b;
  localparam logic [7:0] IDX_OPTION = 8'h81;
  localparam logic [7:0] IDX_DIR_PORT_A = 8'h85;
  localparam logic [7:0] IDX_DIR_PORT_B = 8'h86;
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h8e;

  // interrupt_control fields
  localparam int unsigned IC_GIE = 7;
  localparam int unsigned IC_EN_LO = 3;
  localparam int unsigned IC_FLAG_LO = 0;
  localparam int unsigned IC_TIMER_OVF_FLAG = 2;
  localparam int unsigned IC_INTF = 1;
  localparam int unsigned IC_PORT_CHANGE_FLAG = 0;
  // core_status, option_config and power_control fields
  localparam int unsigned ST_TO = 4;
  localparam int unsigned ST_PD = 3;
  localparam int unsigned OPT_EDGE = 6;
  localparam int unsigned POWER_CONTROL_POR = 1;

  // reset values
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [4:0] DIR_PORT_A_RST = 5'h1f;
  localparam logic [7:0] DIR_PORT_B_RST = 8'hff;
  localparam logic [7:0] PCL_RST = 8'h00;
  localparam logic [4:0] PC_HIGH_LATCH_RST = 5'h00;
  localparam logic [7:0] INTERRUPT_CONTROL_KEEP = 8'h01;
  localparam logic [7:0] STATUS_POR = 8'h18;
  localparam logic [7:0] POWER_CONTROL_RST = 8'h00;
  localparam logic [12:0] PC_RESET = 13'h000;
  localparam logic [12:0] PC_VECTOR = 13'h004;

  typedef enum logic [2:0] {S_PWRT, S_OST, S_RUN, S_SLEEP, S_HOLD} rcu_state_t;
endpackage

// File: tb/rcu_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module rcu_core_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic core_reset_in,
  input wire logic pc_load_in,
  input wire logic [12:0] pc_value_in,
  input wire logic wake_in,
  output logic instr_strobe_out,
  output logic [7:0] vec_cnt_out,
  output logic [7:0] wake_cnt_out
);
  import rcu_pkg::*;
  logic [1:0] phase_r;
  // four clocks to one instruction cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end
  // no instructions run while the core is held
  assign instr_strobe_out = (phase_r == 2'h3) && !core_reset_in;
  // count vector loads and resumes seen by the core
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      vec_cnt_out <= 8'h00;
      wake_cnt_out <= 8'h00;
    end else begin
      if (pc_load_in && !core_reset_in && pc_value_in == PC_VECTOR) begin
        vec_cnt_out <= vec_cnt_out + 8'h01;
      end
      if (wake_in) begin
        wake_cnt_out <= wake_cnt_out + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/rcu_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module rcu_top_tb;
  import rcu_pkg::*;
  localparam int PWRT = 20;
  localparam logic [9:0] a_pcl = 10'h008, a_stat = 10'h00c, a_pch = 10'h028, a_ic = 10'h02c;
  localparam logic [9:0] a_opt = 10'h204, a_dira = 10'h214, a_dirb = 10'h218, a_pwr = 10'h238;
  logic clk_in = 1'b0, rst_n_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out, master_clear_pin_n, ext_pin, tovf, wdt, slp;
  logic ret, strobe, core_reset_out, pc_load_out, wake_out, irq_req_out;
  logic [9:0] wb_adr_in;
  logic [31:0] wb_dat_in, wb_dat_out;
  logic [3:0] pb;
  logic [12:0] pc_value_out;
  logic [7:0] vec_cnt, wake_cnt;
  int errors, num_checks;
  always #5 clk_in = ~clk_in;
  rcu_top #(.PWRT_CYC(PWRT)) rcu_top_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(4'h1),
    .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .master_clear_pin_n_in(master_clear_pin_n),
    .ext_irq_pin_in(ext_pin), .port_b_pins_in(pb), .timer_ovf_in(tovf), .watchdog_timeout_in(wdt),
    .sleep_in(slp), .return_from_irq_in(ret), .instr_strobe_in(strobe), .powerup_timer_disable_in(1'b0),
    .resistor_cap_osc_in(1'b0), .core_reset_out(core_reset_out), .pc_load_out(pc_load_out),
    .pc_value_out(pc_value_out), .wake_out(wake_out), .irq_req_out(irq_req_out));
  rcu_core_model rcu_core_model_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .core_reset_in(core_reset_out),
    .pc_load_in(pc_load_out), .pc_value_in(pc_value_out), .wake_in(wake_out), .instr_strobe_out(strobe),
    .vec_cnt_out(vec_cnt), .wake_cnt_out(wake_cnt));
  // one classic single cycle; request held until ack is sampled
  task automatic bus(input logic we, input logic [9:0] adr, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge clk_in);
    {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} <= {2'b11, we, adr, 24'h0, wd};
    do begin @(posedge clk_in); end while (wb_ack_out !== 1'b1);
    rd = wb_dat_out[7:0];
    {wb_cyc_in, wb_stb_in, wb_we_in} <= 3'b000;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [7:0] mask, input logic [7:0] e);
    logic [7:0] r;
    bus(1'b0, a, 8'h00, r);
    `CHK(r & mask, e)
  endtask
  task automatic pulse(input int k);
    @(posedge clk_in);
    case (k) 0: tovf <= 1'b1; 1: wdt <= 1'b1; 2: slp <= 1'b1; default: ret <= 1'b1; endcase
    @(posedge clk_in);
    {tovf, wdt, slp, ret} <= 4'h0;
  endtask
  // wait for the core hold to start, then count cycles until it ends
  task automatic wait_run(output int n);
    for (n = 0; n < 10 && core_reset_out !== 1'b1; n++) @(posedge clk_in);
    for (n = 0; n < 3000 && core_reset_out !== 1'b0; n++) @(posedge clk_in);
  endtask
  task automatic t_por();
    int n;
    `CHK({pc_load_out, pc_value_out}, {1'b1, PC_RESET})
    wait_run(n);
    `CHK(n >= PWRT + OST_TOSC && n <= PWRT + OST_TOSC + 4, 1'b1)
    rd_chk(a_stat, 8'hff, 8'h18);
    rd_chk(a_pwr, 8'hff, 8'h00);
    rd_chk(a_opt, 8'hff, 8'hff);
    rd_chk(a_dira, 8'hff, 8'h1f);
    rd_chk(a_dirb, 8'hff, 8'hff);
    rd_chk(a_pcl, 8'hff, 8'h00);
    rd_chk(a_pch, 8'hff, 8'h00);
    rd_chk(a_ic, 8'hfe, 8'h00);
    rd_chk(10'h3fc, 8'hff, 8'h00);
    wr(a_pwr, 8'h02);
    rd_chk(a_pwr, 8'hff, 8'h02);
  endtask
  // timer event with its enable set but the global enable off
  task automatic t_mask();
    int n, hits;
    wr(a_ic, 8'h20);
    pulse(0);
    hits = 0;
    for (n = 0; n < 16; n++) begin @(posedge clk_in); hits += (irq_req_out === 1'b1); end
    `CHK(hits, 0)
    rd_chk(a_ic, 8'hff, 8'h24);
    wr(a_ic, 8'h00);
  endtask
  // pin and port events with vectoring on, both edges of the pin
  task automatic t_vector();
    int n;
    logic [7:0] v0;
    v0 = vec_cnt;
    wr(a_ic, 8'h90);
    @(posedge clk_in);
    {pb, ext_pin} <= {4'h5, 1'b1};
    for (n = 0; n < 40 && vec_cnt === v0; n++) @(posedge clk_in);
    `CHK(n <= 24, 1'b1)
    `CHK(vec_cnt, v0 + 8'h01)
    rd_chk(a_ic, 8'hff, 8'h13);
    wr(a_ic, 8'h10);
    pulse(3);
    rd_chk(a_ic, 8'hff, 8'h90);
    wr(a_opt, 8'hbf);
    @(posedge clk_in);
    ext_pin <= 1'b0;
    repeat (30) @(posedge clk_in);
    `CHK(vec_cnt, v0 + 8'h02)
    wr(a_ic, 8'h10);
    pulse(3);
    wr(a_ic, 8'h00);
  endtask
  // watchdog wake, then pin wake without vectoring
  task automatic t_sleep();
    int n;
    logic [7:0] w0, v0;
    w0 = wake_cnt;
    v0 = vec_cnt;
    pulse(2);
    rd_chk(a_stat, 8'h18, 8'h10);
    pulse(1);
    for (n = 0; n < 1200 && wake_cnt === w0; n++) @(posedge clk_in);
    `CHK(wake_cnt, w0 + 8'h01)
    rd_chk(a_stat, 8'h18, 8'h00);
    wr(a_ic, 8'h10);
    // falling edge is selected here: raise the pin first, drop it while asleep
    @(posedge clk_in);
    ext_pin <= 1'b1;
    repeat (4) @(posedge clk_in);
    pulse(2);
    @(posedge clk_in);
    ext_pin <= 1'b0;
    for (n = 0; n < 1200 && wake_cnt === (w0 + 8'h01); n++) @(posedge clk_in);
    `CHK(wake_cnt, w0 + 8'h02)
    rd_chk(a_stat, 8'h18, 8'h10);
    rd_chk(a_ic, 8'hfe, 8'h12);
    `CHK(vec_cnt, v0)
    rd_chk(a_pwr, 8'hff, 8'h02);
  endtask
  // watchdog reset while running, then a clear-pin reset
  task automatic t_resets();
    int n;
    wr(a_ic, 8'h80);
    pulse(1);
    for (n = 0; n < 6 && pc_load_out !== 1'b1; n++) @(posedge clk_in);
    `CHK(pc_value_out, PC_RESET)
    wait_run(n);
    rd_chk(a_stat, 8'h18, 8'h08);
    rd_chk(a_pwr, 8'hff, 8'h02);
    rd_chk(a_opt, 8'hff, 8'hff);
    rd_chk(a_ic, 8'hfe, 8'h00);
    @(posedge clk_in);
    master_clear_pin_n <= 1'b0;
    repeat (6) @(posedge clk_in);
    master_clear_pin_n <= 1'b1;
    wait_run(n);
    rd_chk(a_stat, 8'h18, 8'h18);
    rd_chk(a_pwr, 8'hff, 8'h02);
  endtask
  task automatic stop_test();
    $display("errors=%0d num_checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    errors = 0;
    num_checks = 0;
    {rst_n_in, wb_cyc_in, wb_stb_in, wb_we_in, ext_pin, tovf, wdt, slp, ret} = 9'h0;
    {wb_adr_in, wb_dat_in, pb, master_clear_pin_n} = {10'h0, 32'h0, 4'h0, 1'b1};
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_por();
    t_mask();
    t_vector();
    t_sleep();
    t_resets();
    stop_test();
  end
  // watchdog against a hung wait
  initial begin
    repeat (40000) @(posedge clk_in);
    errors++;
    stop_test();
  end
endmodule
`default_nettype wire

// File: verilog/rcu_top.sv
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rcu_top #(
  parameter int unsigned PWRT_CYC = rcu_pkg::PWRT_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [9:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic master_clear_pin_n_in,
  input wire logic ext_irq_pin_in,
  input wire logic [3:0] port_b_pins_in,
  input wire logic timer_ovf_in,
  input wire logic watchdog_timeout_in,
  input wire logic sleep_in,
  input wire logic return_from_irq_in,
  input wire logic instr_strobe_in,
  input wire logic powerup_timer_disable_in,
  input wire logic resistor_cap_osc_in,
  output logic core_reset_out,
  output logic pc_load_out,
  output logic [12:0] pc_value_out,
  output logic wake_out,
  output logic irq_req_out
);
  import rcu_pkg::*;

  rcu_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic master_clear_pin_s1_r, master_clear_pin_s2_r, ext_s1_r, ext_s2_r, ext_d_r;
  logic [3:0] pb_s1_r, pb_s2_r, pb_d_r;
  logic [7:0] status_r, interrupt_control_r, interrupt_control_nxt, option_r, dir_port_b_r, pcl_r, power_control_r;
  logic [4:0] dir_port_a_r, pc_high_latch_r;
  logic wake_pend_r, wake_irq_r, block_r, ack_r;
  logic [31:0] dat_r;
  logic core_reset_r, pc_load_r, wake_r, pend_r;
  logic [12:0] pc_value_r;
  logic [7:0] idx;
  logic bus_wr, master_clear_pin_low, ext_evt, pb_evt, wdt_rst, regs_rst, irq_any, vec_fire, done_pwrt, wake_evt;

  // two-stage synchronisers for pins, plus a delay stage after the edge-detected ones
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      master_clear_pin_s1_r <= 1'b1;
      master_clear_pin_s2_r <= 1'b1;
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_d_r <= 1'b0;
      pb_s1_r <= 4'h0;
      pb_s2_r <= 4'h0;
      pb_d_r <= 4'h0;
    end else begin
      master_clear_pin_s1_r <= master_clear_pin_n_in;
      master_clear_pin_s2_r <= master_clear_pin_s1_r;
      ext_s1_r <= ext_irq_pin_in;
      ext_s2_r <= ext_s1_r;
      ext_d_r <= ext_s2_r;
      pb_s1_r <= port_b_pins_in;
      pb_s2_r <= pb_s1_r;
      pb_d_r <= pb_s2_r;
    end
  end

  // event detection and reset causes
  assign master_clear_pin_low = !master_clear_pin_s2_r;
  assign ext_evt = option_r[OPT_EDGE] ? (ext_s2_r & !ext_d_r) : (!ext_s2_r & ext_d_r);
  assign pb_evt = |(pb_s2_r ^ pb_d_r);
  assign wdt_rst = watchdog_timeout_in && (state_r == S_RUN);
  assign regs_rst = (state_r == S_HOLD) || wdt_rst;
  assign irq_any = |(interrupt_control_r[IC_EN_LO+:3] & interrupt_control_r[IC_FLAG_LO+:3]);
  assign wake_evt = watchdog_timeout_in || irq_any;
  assign done_pwrt = powerup_timer_disable_in || (cnt_r >= CNT_W'(PWRT_CYC - 1));
  assign vec_fire = instr_strobe_in && pend_r && interrupt_control_r[IC_GIE] && (state_r == S_RUN);
  assign idx = wb_adr_in[9:2];
  assign bus_wr = wb_cyc_in && wb_stb_in && wb_we_in && ack_r && wb_sel_in[0];

  // start-up, sleep and clear-pin sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_PWRT: begin
        if (done_pwrt) begin
          state_nxt = resistor_cap_osc_in ? S_RUN : S_OST;
        end
      end
      S_OST: begin
        if (cnt_r == CNT_W'(OST_CYCLES - 1)) begin
          state_nxt = S_RUN;
        end
      end
      S_RUN: begin
        if (master_clear_pin_low) begin
          state_nxt = S_HOLD;
        end else if (sleep_in) begin
          state_nxt = S_SLEEP;
        end
      end
      S_SLEEP: begin
        if (master_clear_pin_low) begin
          state_nxt = S_HOLD;
        end else if (wake_evt) begin
          state_nxt = resistor_cap_osc_in ? S_RUN : S_OST;
        end
      end
      S_HOLD: begin
        if (!master_clear_pin_low) begin
          state_nxt = S_RUN;
        end
      end
      default: state_nxt = S_PWRT;
    endcase
  end

  // state, time-out counter and wake bookkeeping
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= S_PWRT;
      cnt_r <= '0;
      wake_pend_r <= 1'b0;
      wake_irq_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= (state_nxt != state_r) ? '0 : cnt_r + 1'b1;
      if (state_r == S_SLEEP && state_nxt != S_SLEEP) begin
        wake_pend_r <= (state_nxt != S_HOLD);
        wake_irq_r <= !watchdog_timeout_in;
      end else if (state_r == S_OST && state_nxt == S_RUN) begin
        wake_pend_r <= 1'b0;
      end
    end
  end

  // core reset, pc load and wake outputs
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      core_reset_r <= 1'b1;
      pc_load_r <= 1'b1;
      pc_value_r <= PC_RESET;
      wake_r <= 1'b0;
    end else begin
      core_reset_r <= (state_nxt == S_PWRT) || (state_nxt == S_HOLD) || wdt_rst ||
                      (state_nxt == S_OST && !(wake_pend_r || state_r == S_SLEEP));
      pc_load_r <= (state_nxt == S_HOLD) || wdt_rst || (state_nxt == S_PWRT) || vec_fire ||
                   (state_nxt == S_OST && !(wake_pend_r || state_r == S_SLEEP));
      pc_value_r <= vec_fire ? PC_VECTOR : PC_RESET;
      wake_r <= (state_nxt == S_RUN) && ((state_r == S_SLEEP) || (state_r == S_OST && wake_pend_r));
    end
  end

  // core status: time-out and power-down flags per cause
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_r <= STATUS_POR;
    end else if (wdt_rst) begin
      status_r <= {3'b000, 1'b0, 1'b1, status_r[2:0]};
    end else if (state_r == S_RUN && master_clear_pin_low) begin
      status_r <= {3'b000, 1'b1, 1'b1, status_r[2:0]};
    end else if (state_r == S_SLEEP && master_clear_pin_low) begin
      status_r <= {3'b000, 1'b1, 1'b0, status_r[2:0]};
    end else if (state_r == S_SLEEP && watchdog_timeout_in) begin
      status_r <= {status_r[7:5], 1'b0, 1'b0, status_r[2:0]};
    end else if (state_r == S_SLEEP && irq_any) begin
      status_r <= {status_r[7:5], 1'b1, 1'b0, status_r[2:0]};
    end else if (state_r == S_RUN && sleep_in) begin
      status_r <= {status_r[7:5], 1'b1, 1'b0, status_r[2:0]};
    end else if (bus_wr && idx == IDX_STATUS) begin
      status_r <= {wb_dat_in[7:5], status_r[ST_TO], status_r[ST_PD], wb_dat_in[2:0]};
    end
  end

  // power control: only power-on reset or a bus write clears the flag
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      power_control_r <= POWER_CONTROL_RST;
    end else if (bus_wr && idx == IDX_POWER_CONTROL) begin
      power_control_r <= {6'h00, wb_dat_in[POWER_CONTROL_POR], 1'b0};
    end
  end

  // configuration registers reset by every reset kind
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      option_r <= OPTION_RST;
      dir_port_a_r <= DIR_PORT_A_RST;
      dir_port_b_r <= DIR_PORT_B_RST;
      pcl_r <= PCL_RST;
      pc_high_latch_r <= PC_HIGH_LATCH_RST;
    end else if (regs_rst) begin
      option_r <= OPTION_RST;
      dir_port_a_r <= DIR_PORT_A_RST;
      dir_port_b_r <= DIR_PORT_B_RST;
      pcl_r <= PCL_RST;
      pc_high_latch_r <= PC_HIGH_LATCH_RST;
    end else if (bus_wr) begin
      if (idx == IDX_OPTION) option_r <= wb_dat_in[7:0];
      if (idx == IDX_DIR_PORT_A) dir_port_a_r <= wb_dat_in[4:0];
      if (idx == IDX_DIR_PORT_B) dir_port_b_r <= wb_dat_in[7:0];
      if (idx == IDX_PCL) pcl_r <= wb_dat_in[7:0];
      if (idx == IDX_PC_HIGH_LATCH) pc_high_latch_r <= wb_dat_in[4:0];
    end
  end

  // interrupt control next value; event sets win over clears
  always_comb begin
    interrupt_control_nxt = interrupt_control_r;
    if (bus_wr && idx == IDX_INTERRUPT_CONTROL) begin
      interrupt_control_nxt = wb_dat_in[7:0];
    end
    if (return_from_irq_in) begin
      interrupt_control_nxt[IC_GIE] = 1'b1;
    end
    if (vec_fire) begin
      interrupt_control_nxt[IC_GIE] = 1'b0;
    end
    if (regs_rst) begin
      interrupt_control_nxt = interrupt_control_r & INTERRUPT_CONTROL_KEEP;
    end
    interrupt_control_nxt[IC_INTF] = interrupt_control_nxt[IC_INTF] | ext_evt;
    interrupt_control_nxt[IC_TIMER_OVF_FLAG] = interrupt_control_nxt[IC_TIMER_OVF_FLAG] | timer_ovf_in;
    interrupt_control_nxt[IC_PORT_CHANGE_FLAG] = interrupt_control_nxt[IC_PORT_CHANGE_FLAG] | pb_evt;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      interrupt_control_r <= 8'h00;
    end else begin
      interrupt_control_r <= interrupt_control_nxt;
    end
  end

  // request sampling once per instruction; cleared enable blocks one cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      block_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      if (interrupt_control_r[IC_GIE] && !interrupt_control_nxt[IC_GIE] && !vec_fire) begin
        block_r <= 1'b1;
      end else if (instr_strobe_in) begin
        block_r <= 1'b0;
      end
      if (regs_rst || vec_fire) begin
        pend_r <= 1'b0;
      end else if (instr_strobe_in) begin
        pend_r <= interrupt_control_r[IC_GIE] && irq_any && !block_r && (state_r == S_RUN);
      end
    end
  end

  // wishbone slave, one wait state; unmapped reads give zero
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_cyc_in && wb_stb_in && !ack_r;
      case (idx)
        IDX_PCL: dat_r <= {24'h000000, pcl_r};
        IDX_STATUS: dat_r <= {24'h000000, status_r};
        IDX_PC_HIGH_LATCH: dat_r <= {27'h0000000, pc_high_latch_r};
        IDX_INTERRUPT_CONTROL: dat_r <= {24'h000000, interrupt_control_r};
        IDX_OPTION: dat_r <= {24'h000000, option_r};
        IDX_DIR_PORT_A: dat_r <= {27'h0000000, dir_port_a_r};
        IDX_DIR_PORT_B: dat_r <= {24'h000000, dir_port_b_r};
        IDX_POWER_CONTROL: dat_r <= {24'h000000, power_control_r};
        default: dat_r <= 32'h0000_0000;
      endcase
    end
  end

  // outputs straight from flip-flops
  assign wb_ack_out = ack_r;
  assign wb_dat_out = dat_r;
  assign core_reset_out = core_reset_r;
  assign pc_load_out = pc_load_r;
  assign pc_value_out = pc_value_r;
  assign wake_out = wake_r;
  assign irq_req_out = pend_r;

  // checks
  vector_gie_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    vec_fire && !return_from_irq_in |=> !interrupt_control_r[IC_GIE] && pc_load_out && pc_value_out == PC_VECTOR)
    else $error("vector did not clear enable or load 0004h");
  rfi_gie_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    return_from_irq_in && !vec_fire && !regs_rst |=> interrupt_control_r[IC_GIE])
    else $error("return did not set global enable");
  ext_flag_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(ext_s2_r) && option_r[OPT_EDGE] |=> interrupt_control_r[IC_INTF])
    else $error("external flag not set on chosen edge");
  timer_flag_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    timer_ovf_in |=> interrupt_control_r[IC_TIMER_OVF_FLAG])
    else $error("timer flag not set");
  gie_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    instr_strobe_in && !interrupt_control_r[IC_GIE] |=> !irq_req_out)
    else $error("request passed with enable off");
  wdt_status_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wdt_rst |=> status_r[ST_TO:ST_PD] == 2'b01 && core_reset_out && pc_load_out && pc_value_out == PC_RESET)
    else $error("watchdog reset flags wrong");
  sleep_wdt_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_r == S_SLEEP && watchdog_timeout_in && !master_clear_pin_low |=> status_r[ST_TO:ST_PD] == 2'b00)
    else $error("watchdog wake flags wrong");
  reset_regs_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    regs_rst |=> option_r == OPTION_RST && dir_port_b_r == DIR_PORT_B_RST && !interrupt_control_r[IC_GIE] && pc_high_latch_r == PC_HIGH_LATCH_RST)
    else $error("reset values not loaded");
  power_control_keep_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    regs_rst && !(bus_wr && idx == IDX_POWER_CONTROL) |=> power_control_r == $past(power_control_r))
    else $error("power flag changed by other reset");
  block_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    block_r && instr_strobe_in |=> !irq_req_out)
    else $error("request taken in blocked cycle");
endmodule
`default_nettype wire
